// *** rtl/tic_pkg.sv ***
// Shared constants for the time interval counter block
package tic_pkg;
   // Register addresses on the special-function-register port
   localparam logic [7:0] ADDR_CTRL     = 8'ha1;
   localparam logic [7:0] ADDR_FRACTION = 8'ha2;
   localparam logic [7:0] ADDR_SECONDS  = 8'ha3;
   localparam logic [7:0] ADDR_MINUTES  = 8'ha4;
   localparam logic [7:0] ADDR_HOURS    = 8'ha5;
   localparam logic [7:0] ADDR_TARGET   = 8'ha6;
   // Control register field positions
   localparam int BIT_TICK_EN    = 0;
   localparam int BIT_IVL_EN     = 1;
   localparam int BIT_MATCH_FLAG = 2;
   localparam int BIT_ONE_SHOT   = 3;
   localparam int BIT_TB_LO      = 4;
   localparam int BIT_TB_HI      = 5;
   localparam int BIT_RSVD6      = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE  = 8'h00;
   // Counter terminal values
   localparam logic [7:0] FRACTION_MAX = 8'h7f;
   localparam logic [7:0] SECONDS_MAX  = 8'h3b;
   localparam logic [7:0] MINUTES_MAX  = 8'h3b;
   localparam logic [7:0] HOURS_MAX    = 8'h17;
   // Timebase selector codes
   localparam logic [1:0] TB_FRACTION = 2'h0;
   localparam logic [1:0] TB_SECONDS  = 2'h1;
   localparam logic [1:0] TB_MINUTES  = 2'h2;
   localparam logic [1:0] TB_HOURS    = 2'h3;
   // Crystal divider: 32768 Hz / 256 = 128 Hz
   localparam int XTAL_DIV = 256;
endpackage

// *** rtl/tic_tick_if.sv ***
// Tick signal passed between the block's modules
`timescale 1ns/100ps
interface tic_tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface

// *** rtl/tic_xtal_sync.sv ***
// Crystal clock synchroniser and divide-by-256 tick generator
`timescale 1ns/100ps
module tic_xtal_sync (
   input  wire logic core_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic xtal_in,
   tic_tick_if.src   tk
);
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       last;
      logic [7:0] div;
      logic       tick;
   } tic_sync_s;
   tic_sync_s st_reg;
   tic_sync_s st_next;

   // Count crystal rising edges; pulse tick once per 256 edges
   always_comb begin
      st_next = st_reg;
      st_next.sync1 = xtal_in;
      st_next.sync2 = st_reg.sync1;
      st_next.last  = st_reg.sync2;
      st_next.tick  = 1'b0;
      if (st_reg.sync2 && !st_reg.last) begin
         st_next.div = st_reg.div + 8'h01;
         if (st_reg.div == 8'((tic_pkg::XTAL_DIV) - 1)) begin
            st_next.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tk.tick = st_reg.tick;
endmodule

// *** rtl/tic_cascade.sv ***
// Cascaded fraction, second, minute and hour counters
`timescale 1ns/100ps
module tic_cascade (
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       run_in,
   input  wire logic       clr_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   tic_tick_if.snk         tk,
   output      logic [7:0] fraction_out,
   output      logic [7:0] seconds_out,
   output      logic [7:0] minutes_out,
   output      logic [7:0] hours_out,
   output      logic [3:0] wrap_out
);
   typedef struct packed {
      logic [7:0] fr;
      logic [7:0] sc;
      logic [7:0] mn;
      logic [7:0] hr;
      logic [3:0] wrap;
   } tic_casc_s;
   tic_casc_s st_reg;
   tic_casc_s st_next;
   logic      adv;
   assign adv = run_in && tk.tick;

   // Ripple carry through the four time registers
   always_comb begin
      st_next      = st_reg;
      st_next.wrap = 4'h0;
      if (clr_in) begin
         st_next.fr = tic_pkg::ZERO_BYTE;
         st_next.sc = tic_pkg::ZERO_BYTE;
         st_next.mn = tic_pkg::ZERO_BYTE;
         st_next.hr = tic_pkg::ZERO_BYTE;
      end else if (adv) begin
         st_next.wrap[0] = 1'b1;
         if (st_reg.fr >= tic_pkg::FRACTION_MAX) begin
            st_next.fr      = tic_pkg::ZERO_BYTE;
            st_next.wrap[1] = 1'b1;
            if (st_reg.sc >= tic_pkg::SECONDS_MAX) begin
               st_next.sc      = tic_pkg::ZERO_BYTE;
               st_next.wrap[2] = 1'b1;
               if (st_reg.mn >= tic_pkg::MINUTES_MAX) begin
                  st_next.mn      = tic_pkg::ZERO_BYTE;
                  st_next.wrap[3] = 1'b1;
                  if (st_reg.hr >= tic_pkg::HOURS_MAX) begin
                     st_next.hr = tic_pkg::ZERO_BYTE;
                  end else begin
                     st_next.hr = st_reg.hr + 8'h01;
                  end
               end else begin
                  st_next.mn = st_reg.mn + 8'h01;
               end
            end else begin
               st_next.sc = st_reg.sc + 8'h01;
            end
         end else begin
            st_next.fr = st_reg.fr + 8'h01;
         end
      end else if (wr_in && !run_in) begin
         case (addr_in)
            tic_pkg::ADDR_FRACTION: st_next.fr = wdata_in;
            tic_pkg::ADDR_SECONDS:  st_next.sc = wdata_in;
            tic_pkg::ADDR_MINUTES:  st_next.mn = wdata_in;
            tic_pkg::ADDR_HOURS:    st_next.hr = wdata_in;
            default:                st_next.fr = st_reg.fr;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fraction_out = st_reg.fr;
   assign seconds_out  = st_reg.sc;
   assign minutes_out  = st_reg.mn;
   assign hours_out    = st_reg.hr;
   assign wrap_out     = st_reg.wrap;
endmodule

// *** rtl/tic_top.sv ***
// Time interval counter top: control, interval counter and register port
`timescale 1ns/100ps
module tic_top (
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       xtal_in,
   input  wire logic       sfr_wr_in,
   input  wire logic       sfr_rd_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic [7:0] sfr_wdata_in,
   input  wire logic       irq_enable_in,
   input  wire logic       power_down_in,
   output      logic [7:0] sfr_rdata_out,
   output      logic       sfr_hit_out,
   output      logic       irq_out,
   output      logic       wake_out
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] target;
      logic [7:0] ivl;
      logic [7:0] rdata;
      logic       hit;
      logic       irq;
      logic       wake;
   } tic_top_s;
   tic_top_s   st_reg;
   tic_top_s   st_next;
   tic_tick_if tk ();
   logic [7:0] fr;
   logic [7:0] sc;
   logic [7:0] mn;
   logic [7:0] hr;
   logic [3:0] wraps;
   logic       run;
   logic       ivl_step;
   logic       wr_ctrl;
   logic       time_clr;

   // tick derived from the crystal, not the core PLL
   tic_xtal_sync u_sync (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .xtal_in     (xtal_in),
      .tk          (tk)
   );

   assign run = st_reg.ctrl[tic_pkg::BIT_TICK_EN];

   // dropping the gate clears times
   // Only the falling write clears, so loads made while stopped survive
   assign time_clr = wr_ctrl && run && !sfr_wdata_in[tic_pkg::BIT_TICK_EN];

   tic_cascade u_casc (
      .core_clk_in  (core_clk_in),
      .sys_rst_in   (sys_rst_in),
      .run_in       (run),
      .clr_in       (time_clr),
      .wr_in        (sfr_wr_in),
      .addr_in      (sfr_addr_in),
      .wdata_in     (sfr_wdata_in),
      .tk           (tk),
      .fraction_out (fr),
      .seconds_out  (sc),
      .minutes_out  (mn),
      .hours_out    (hr),
      .wrap_out     (wraps)
   );

   ////////////////////////////////////////////////////////////////////////////
   // select timebase overflow
   always_comb begin
      case (st_reg.ctrl[tic_pkg::BIT_TB_HI:tic_pkg::BIT_TB_LO])
         tic_pkg::TB_FRACTION: ivl_step = wraps[0];
         tic_pkg::TB_SECONDS:  ivl_step = wraps[1];
         tic_pkg::TB_MINUTES:  ivl_step = wraps[2];
         tic_pkg::TB_HOURS:    ivl_step = wraps[3];
         default:              ivl_step = 1'b0;
      endcase
   end

   assign wr_ctrl = sfr_wr_in && (sfr_addr_in == tic_pkg::ADDR_CTRL);

   // Control, interval counter and read path
   always_comb begin
      st_next = st_reg;
      // bits 7:6 stored as written, software owns them
      if (wr_ctrl) begin
         st_next.ctrl = sfr_wdata_in;
      end
      if (sfr_wr_in && sfr_addr_in == tic_pkg::ADDR_TARGET) begin
         st_next.target = sfr_wdata_in;
      end
      if (!st_reg.ctrl[tic_pkg::BIT_IVL_EN] || !run) begin
         st_next.ivl = tic_pkg::ZERO_BYTE;
      end else if (ivl_step) begin
         st_next.ivl = st_reg.ivl + 8'h01;
         if (st_next.ivl == st_reg.target) begin
            // match sets sticky flag; set beats a same-cycle clear
            st_next.ctrl[tic_pkg::BIT_MATCH_FLAG] = 1'b1;
            st_next.ivl = tic_pkg::ZERO_BYTE;
            if (st_reg.ctrl[tic_pkg::BIT_ONE_SHOT]) begin
               st_next.ctrl[tic_pkg::BIT_IVL_EN] = 1'b0;
            end
         end
      end
      st_next.irq  = st_next.ctrl[tic_pkg::BIT_MATCH_FLAG] && irq_enable_in;
      st_next.wake = st_next.irq && power_down_in;
      st_next.hit  = sfr_rd_in && (sfr_addr_in >= tic_pkg::ADDR_CTRL) && (sfr_addr_in <= tic_pkg::ADDR_TARGET);
      case (sfr_addr_in)
         tic_pkg::ADDR_CTRL:     st_next.rdata = st_reg.ctrl;
         tic_pkg::ADDR_FRACTION: st_next.rdata = fr;
         tic_pkg::ADDR_SECONDS:  st_next.rdata = sc;
         tic_pkg::ADDR_MINUTES:  st_next.rdata = mn;
         tic_pkg::ADDR_HOURS:    st_next.rdata = hr;
         tic_pkg::ADDR_TARGET:   st_next.rdata = st_reg.target;
         default:                st_next.rdata = tic_pkg::ZERO_BYTE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sfr_rdata_out = st_reg.rdata;
   assign sfr_hit_out   = st_reg.hit;
   assign irq_out       = st_reg.irq;
   assign wake_out      = st_reg.wake;

   ////////////////////////////////////////////////////////////////////////////
   a_flag_sticky: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      st_reg.ctrl[tic_pkg::BIT_MATCH_FLAG] && !wr_ctrl |=> st_reg.ctrl[tic_pkg::BIT_MATCH_FLAG])
      else $error("match flag dropped");
   a_irq_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !irq_enable_in |=> !irq_out)
      else $error("irq without enable");
   a_ivl_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !st_reg.ctrl[tic_pkg::BIT_IVL_EN] |=> st_reg.ivl == tic_pkg::ZERO_BYTE)
      else $error("interval counter not cleared");
   a_one_shot: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      run && ivl_step && st_reg.ctrl[tic_pkg::BIT_IVL_EN] && st_reg.ctrl[tic_pkg::BIT_ONE_SHOT] && !wr_ctrl
      && (st_reg.ivl + 8'h01 == st_reg.target) |=> !st_reg.ctrl[tic_pkg::BIT_IVL_EN])
      else $error("one-shot did not stop");
   a_reload: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      run && ivl_step && st_reg.ctrl[tic_pkg::BIT_IVL_EN] && (st_reg.ivl + 8'h01 == st_reg.target)
      |=> st_reg.ivl == tic_pkg::ZERO_BYTE && st_reg.ctrl[tic_pkg::BIT_MATCH_FLAG])
      else $error("timeout did not reload");
   a_sec_range: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      run && sc <= tic_pkg::SECONDS_MAX |=> sc <= tic_pkg::SECONDS_MAX)
      else $error("seconds out of range");
   a_hour_range: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      run && hr <= tic_pkg::HOURS_MAX |=> hr <= tic_pkg::HOURS_MAX)
      else $error("hours out of range");
   a_stop_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !run && !sfr_wr_in |=> $stable(fr) && $stable(hr))
      else $error("time moved while stopped");
   a_gate_clear: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      time_clr |=> fr == tic_pkg::ZERO_BYTE && sc == tic_pkg::ZERO_BYTE
      && mn == tic_pkg::ZERO_BYTE && hr == tic_pkg::ZERO_BYTE)
      else $error("time registers not cleared");
endmodule

// *** verif/tic_tb.sv ***
// Self-checking testbench for the time interval counter top
`timescale 1ns/100ps
module testbench;
   logic        core_clk_in   = 1'b0;
   logic        sys_rst_in    = 1'b1;
   logic        xtal_in       = 1'b0;
   logic        sfr_wr_in     = 1'b0;
   logic        sfr_rd_in     = 1'b0;
   logic [7:0]  sfr_addr_in   = 8'h00;
   logic [7:0]  sfr_wdata_in  = 8'h00;
   logic        irq_enable_in = 1'b0;
   logic        power_down_in = 1'b0;
   logic [7:0]  sfr_rdata_out;
   logic        sfr_hit_out;
   logic        irq_out;
   logic        wake_out;
   int          err_total     = 0;
   int          num_checks    = 0;
   int unsigned seed          = 17255;
   logic [15:0] exp_q[$];
   logic [15:0] exp_e;

   tic_top tic_top_i (
      .core_clk_in   (core_clk_in),
      .sys_rst_in    (sys_rst_in),
      .xtal_in       (xtal_in),
      .sfr_wr_in     (sfr_wr_in),
      .sfr_rd_in     (sfr_rd_in),
      .sfr_addr_in   (sfr_addr_in),
      .sfr_wdata_in  (sfr_wdata_in),
      .irq_enable_in (irq_enable_in),
      .power_down_in (power_down_in),
      .sfr_rdata_out (sfr_rdata_out),
      .sfr_hit_out   (sfr_hit_out),
      .irq_out       (irq_out),
      .wake_out      (wake_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Core clock, 40 ns period
   always #20 core_clk_in = ~core_clk_in;

   // Xorshift source for data that the design must refuse
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      num_checks++;
      if (seen !== expv) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Every step lands 1 ns after the rising edge, clear of the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask

   // Idle cycle after each strobe so a strobe is never set and cleared at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_wr_in    = 1'b1;
      sfr_addr_in  = a;
      sfr_wdata_in = d;
      cyc(1);
      sfr_wr_in    = 1'b0;
      cyc(1);
   endtask

   // Expected value and mask are queued before the read goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      exp_q.push_back({m, e});
      sfr_rd_in   = 1'b1;
      sfr_addr_in = a;
      cyc(1);
      sfr_rd_in   = 1'b0;
      cyc(1);
   endtask

   task automatic rdt(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
      rd(tic_pkg::ADDR_FRACTION, f);
      rd(tic_pkg::ADDR_SECONDS, s);
      rd(tic_pkg::ADDR_MINUTES, m);
      rd(tic_pkg::ADDR_HOURS, h);
   endtask

   // Counters only load while the tick gate is off; bit 6 written as one
   task automatic load(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
      wr(tic_pkg::ADDR_CTRL, 8'h40);
      wr(tic_pkg::ADDR_FRACTION, f);
      wr(tic_pkg::ADDR_SECONDS, s);
      wr(tic_pkg::ADDR_MINUTES, m);
      wr(tic_pkg::ADDR_HOURS, h);
   endtask

   // Whole ticks only, so the crystal divider stays aligned across calls
   task automatic ticks(input int n);
      repeat (256 * n) begin
         xtal_in = 1'b1;
         cyc(2);
         xtal_in = 1'b0;
         cyc(2);
      end
      cyc(8);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scoreboard: each read answer is matched against the oldest note
   always @(negedge core_clk_in) begin
      if (sfr_hit_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(8'h00, 8'hff);
         end else begin
            exp_e = exp_q.pop_front();
            check(sfr_rdata_out & exp_e[15:8], exp_e[7:0]);
         end
      end
   end

   // Watchdog sized well beyond the roughly 26k cycles of stimulus
   initial begin
      #(40 * 80000);
      err_total++;
      $display("watchdog expired");
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(8);
      sys_rst_in = 1'b0;
      cyc(1);
      for (int i = 0; i < 6; i++) rd(tic_pkg::ADDR_CTRL + 8'(i), 8'h00);
      sfr_rd_in   = 1'b1;
      sfr_addr_in = 8'ha7;
      cyc(1);
      sfr_rd_in   = 1'b0;
      check(sfr_rdata_out, 8'h00);
      check({7'h00, sfr_hit_out}, 8'h00);
      cyc(1);
      $display("test reset done");
      // loads accepted while gated, refused while running
      load(8'h7f, 8'h3b, 8'h3b, 8'h17);
      rdt(8'h7f, 8'h3b, 8'h3b, 8'h17);
      wr(tic_pkg::ADDR_CTRL, 8'h41);
      for (int i = 0; i < 4; i++) wr(tic_pkg::ADDR_FRACTION + 8'(i), rnd());
      rdt(8'h7f, 8'h3b, 8'h3b, 8'h17);
      ticks(1);
      rdt(8'h00, 8'h00, 8'h00, 8'h00);
      ticks(1);
      rdt(8'h01, 8'h00, 8'h00, 8'h00);
      wr(tic_pkg::ADDR_CTRL, 8'h40);
      ticks(1);
      rdt(8'h00, 8'h00, 8'h00, 8'h00);
      $display("test time counters done");
      // match flag, request gating, auto reload
      wr(tic_pkg::ADDR_TARGET, 8'h03);
      rd(tic_pkg::ADDR_TARGET, 8'h03);
      wr(tic_pkg::ADDR_CTRL, 8'h43);
      ticks(2);
      rd(tic_pkg::ADDR_CTRL, 8'h03, 8'h3f);
      irq_enable_in = 1'b1;
      ticks(1);
      rd(tic_pkg::ADDR_CTRL, 8'h07, 8'h3f);
      check({7'h00, irq_out}, 8'h01);
      power_down_in = 1'b1;
      cyc(3);
      check({7'h00, wake_out}, 8'h01);
      irq_enable_in = 1'b0;
      cyc(3);
      check({7'h00, irq_out}, 8'h00);
      check({7'h00, wake_out}, 8'h00);
      ticks(1);
      power_down_in = 1'b0;
      rd(tic_pkg::ADDR_CTRL, 8'h07, 8'h3f);
      wr(tic_pkg::ADDR_CTRL, 8'h43);
      ticks(1);
      rd(tic_pkg::ADDR_CTRL, 8'h03, 8'h3f);
      ticks(1);
      rd(tic_pkg::ADDR_CTRL, 8'h07, 8'h3f);
      $display("test interval reload done");
      wr(tic_pkg::ADDR_CTRL, 8'h43);
      ticks(2);
      wr(tic_pkg::ADDR_CTRL, 8'h41);
      wr(tic_pkg::ADDR_CTRL, 8'h43);
      ticks(2);
      rd(tic_pkg::ADDR_CTRL, 8'h03, 8'h3f);
      ticks(1);
      rd(tic_pkg::ADDR_CTRL, 8'h07, 8'h3f);
      // one-shot clears the enable and stays stopped
      wr(tic_pkg::ADDR_TARGET, 8'h02);
      wr(tic_pkg::ADDR_CTRL, 8'h4b);
      ticks(2);
      rd(tic_pkg::ADDR_CTRL, 8'h0d, 8'h3f);
      wr(tic_pkg::ADDR_CTRL, 8'h49);
      ticks(3);
      rd(tic_pkg::ADDR_CTRL, 8'h09, 8'h3f);
      $display("test interval modes done");
      // each coarse timebase steps only on the overflow of the register below it
      for (int t = 1; t < 4; t++) begin
         load(8'h7e, 8'h3b, 8'h3b, 8'h00);
         wr(tic_pkg::ADDR_TARGET, 8'h01);
         wr(tic_pkg::ADDR_CTRL, 8'h43 | {2'h0, 2'(t), 4'h0});
         ticks(1);
         rd(tic_pkg::ADDR_CTRL, 8'h03 | {2'h0, 2'(t), 4'h0}, 8'h3f);
         ticks(1);
         rd(tic_pkg::ADDR_CTRL, 8'h07 | {2'h0, 2'(t), 4'h0}, 8'h3f);
      end
      $display("test timebase done");
      cyc(4);
      check(8'(exp_q.size()), 8'h00);
      finish_test();
   end
endmodule
